//--- rtl/heater_level_burst.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Three setpoints per channel, 0 to 100
// - Field production factor scales profiles 1, 2
// - Field standby factor scales profile 1
// - Standby: p1 times standby factor times correction
// - Profile 1: p1 times production factor, correction
// - Profile 2: p2 times field factor, correction
// - Start-up uses its setpoint directly
// - Recalculate only channels touched by change
// - Integrate sampled phase voltages over integration time
// - Compensation enable; local compute or adopt master
// - Correction is squared voltage ratio times 100
// - Report all three corrections; master redistributes
// - Channels 1-8/9-16/17-24 use phases a/b/c
// - Out of 80..120 percent: fault, unity correction
// - Lock to phase a, derive b, c crossings
// - Keep switching; bring new levels progressively
// - Half-wave every crossing, full-wave per period
// - 100 decisions per window, 1 or 2 s
// - Round output up to whole percent
// - Superimposed cycle: half percent, alternating levels
// - Static offset table spreads load per phase
// - Half-wave switching keeps polarity balanced
module heater_level_burst
  import heater_pkg::*;
#(
  parameter int unsigned NUM_CH = NUM_CH_DEF,
  parameter int unsigned NUM_FLD = NUM_FLD_DEF,
  parameter int unsigned HCNT_W = HCNT_W_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic zc_phase_a,
  input wire logic vsample_valid,
  input wire logic [15:0] vsample_a,
  input wire logic [15:0] vsample_b,
  input wire logic [15:0] vsample_c,
  output logic [NUM_CH-1:0] ch_on,
  output logic sense_fault
);

  localparam int unsigned FLD_W = (NUM_FLD > 1) ? $clog2(NUM_FLD) : 1;
  localparam int unsigned IDX_W = $clog2(NUM_CH);

  // ****************************************
  // Register storage
  // ****************************************
  logic [6:0] sp_su [NUM_CH];        // Start-up setpoints
  logic [6:0] sp_p1 [NUM_CH];        // Profile 1 setpoints
  logic [6:0] sp_p2 [NUM_CH];        // Profile 2 setpoints
  logic [FLD_W-1:0] ch_fld [NUM_CH]; // Field of each channel
  logic [NUM_CH-1:0] full_mode;      // 1 = full-wave control
  logic [7:0] fac_prod [NUM_FLD];    // Production factors, 0.01 units
  logic [7:0] fac_stby [NUM_FLD];    // Standby factors, 0.01 units
  logic [15:0] norm [3];             // Normalizing voltages
  logic [7:0] corr [3];              // Correction values, percent
  logic [4:0] integ_shift;           // log2 of samples per integration
  mode_t mode;
  logic comp_en;                     // Compensation enabled
  logic sense_fitted;                // Local voltage sensing present
  logic superimp;                    // Half-percent superimposed cycle
  logic [2:0] fault;                 // Sticky sensing faults per phase
  logic [7:0] lvl [NUM_CH];          // Levels in half-percent steps
  logic [NUM_CH-1:0] dirty;          // Channels awaiting recalculation
  corr_state_t cstate;               // Correction engine state, read by status
  logic locked;                      // Crossing timing tracks phase a
  logic local_corr;
  assign local_corr = comp_en & sense_fitted;

  // ****************************************
  // APB decode
  // ****************************************
  logic setup_rd;
  logic wr_fire;
  logic hit;
  logic [31:0] rd_val;
  logic [IDX_W-1:0] a_ch;
  logic [FLD_W-1:0] a_fld;
  logic [1:0] a_ph;
  logic w_ctrl, w_stat, w_integ, w_norm, w_corr, w_fld, w_chan;
  logic [11:0] rel_ch, rel_fld;

  // Request taken on the access cycle before pready rises
  assign setup_rd = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign rel_ch = paddr - CHAN_OFS;
  assign rel_fld = paddr - FIELD_OFS;

  // Address decode and read mux
  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    a_ch = IDX_W'(rel_ch[11:2]);
    a_fld = FLD_W'(rel_fld[11:2]);
    a_ph = paddr[3:2];
    {w_ctrl, w_stat, w_integ, w_norm, w_corr, w_fld, w_chan} = 7'h00;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (paddr == CTRL_OFS) begin
      w_ctrl = 1'b1;
      rd_val = {26'h000_0000, superimp, sense_fitted, comp_en, mode};
    end else if (paddr == STAT_OFS) begin
      w_stat = 1'b1;
      rd_val = {27'h000_0000, 1'b0, 1'b0, fault};
      rd_val[STAT_LOCK_BIT] = locked;
      rd_val[STAT_BUSY_BIT] = (cstate != CS_IDLE);
    end else if (paddr == INTEG_OFS) begin
      w_integ = 1'b1;
      rd_val = {27'h000_0000, integ_shift};
    end else if (paddr >= NORM_OFS && paddr < NORM_OFS + 12'h00C) begin
      w_norm = 1'b1;
      rd_val = {16'h0000, norm[a_ph]};
    end else if (paddr >= CORR_OFS && paddr < CORR_OFS + 12'h00C) begin
      // Live corrections for the master to redistribute
      w_corr = 1'b1;
      rd_val = {24'h00_0000, corr[a_ph]};
    end else if (paddr >= FIELD_OFS && rel_fld < 12'(4 * NUM_FLD)) begin
      w_fld = 1'b1;
      rd_val = {16'h0000, fac_stby[a_fld], fac_prod[a_fld]};
    end else if (paddr >= CHAN_OFS && rel_ch < 12'(4 * NUM_CH)) begin
      w_chan = 1'b1;
      rd_val = 32'h0000_0000;
      rd_val[CH_SU_LSB +: 7] = sp_su[a_ch];
      rd_val[CH_P1_LSB +: 7] = sp_p1[a_ch];
      rd_val[CH_P2_LSB +: 7] = sp_p2[a_ch];
      rd_val[CH_FLD_LSB +: FLD_W] = ch_fld[a_ch];
      rd_val[CH_FULL_BIT] = full_mode[a_ch];
    end else begin
      hit = 1'b0;
    end
  end

  // One wait state, answer and data from flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_rd;
      prdata <= (setup_rd && !pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= setup_rd & ~hit;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Channel setpoints, clamped to 100 percent
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        sp_su[i] <= 7'h00;
        sp_p1[i] <= 7'h00;
        sp_p2[i] <= 7'h00;
        ch_fld[i] <= '0;
      end
      full_mode <= '0;
    end else if (wr_fire && w_chan) begin
      sp_su[a_ch] <= (pwdata[CH_SU_LSB +: 7] > SP_MAX) ? SP_MAX : pwdata[CH_SU_LSB +: 7];
      sp_p1[a_ch] <= (pwdata[CH_P1_LSB +: 7] > SP_MAX) ? SP_MAX : pwdata[CH_P1_LSB +: 7];
      sp_p2[a_ch] <= (pwdata[CH_P2_LSB +: 7] > SP_MAX) ? SP_MAX : pwdata[CH_P2_LSB +: 7];
      ch_fld[a_ch] <= pwdata[CH_FLD_LSB +: FLD_W];
      full_mode[a_ch] <= pwdata[CH_FULL_BIT];
    end
  end

  // Field factors; field 0 exists from reset so a channel always has one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int f = 0; f < NUM_FLD; f++) begin
        fac_prod[f] <= 8'h00;
        fac_stby[f] <= 8'h00;
      end
    end else if (wr_fire && w_fld) begin
      fac_prod[a_fld] <= pwdata[FLD_PROD_LSB +: 8];
      fac_stby[a_fld] <= pwdata[FLD_STBY_LSB +: 8];
    end
  end

  // Mode and options
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= MODE_OFF;
      comp_en <= 1'b0;
      sense_fitted <= 1'b0;
      superimp <= 1'b0;
      integ_shift <= INTEG_RST;
    end else if (wr_fire) begin
      if (w_ctrl) begin
        mode <= mode_t'(pwdata[CTRL_MODE_LSB +: 3]);
        comp_en <= pwdata[CTRL_COMP_BIT];
        sense_fitted <= pwdata[CTRL_SENSE_BIT];
        superimp <= pwdata[CTRL_SUPER_BIT];
      end
      if (w_integ) begin
        integ_shift <= (pwdata[4:0] > 5'h0F) ? 5'h0F : pwdata[4:0];
      end
    end
  end

  // ****************************************
  // Voltage integration and correction
  // ****************************************
  logic [15:0] samp [3];
  logic [31:0] vsum [3];
  logic [15:0] vavg [3];
  logic [15:0] scnt;
  logic integ_done;
  assign samp[0] = vsample_a;
  assign samp[1] = vsample_b;
  assign samp[2] = vsample_c;

  // Sum 2^shift samples per phase, then average by shifting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scnt <= 16'h0000;
      integ_done <= 1'b0;
      for (int p = 0; p < 3; p++) begin
        vsum[p] <= 32'h0000_0000;
        vavg[p] <= 16'h0000;
      end
    end else begin
      integ_done <= 1'b0;
      if (!local_corr) begin
        scnt <= 16'h0000;
        for (int p = 0; p < 3; p++) vsum[p] <= 32'h0000_0000;
      end else if (vsample_valid) begin
        if (scnt == 16'((32'h1 << integ_shift) - 1)) begin
          scnt <= 16'h0000;
          integ_done <= 1'b1;
          for (int p = 0; p < 3; p++) begin
            vavg[p] <= 16'((vsum[p] + 32'(samp[p])) >> integ_shift);
            vsum[p] <= 32'h0000_0000;
          end
        end else begin
          scnt <= scnt + 16'h0001;
          for (int p = 0; p < 3; p++) vsum[p] <= vsum[p] + 32'(samp[p]);
        end
      end
    end
  end

  logic [1:0] cph;        // Phase under division
  logic [3:0] cbit;       // Quotient bit being tried
  logic [40:0] rem;
  logic [31:0] den;
  logic [8:0] quot;
  logic bad;
  logic [1:0] ld_ph;
  logic [40:0] ld_num;
  logic [31:0] ld_den;
  logic ld_bad;
  logic [40:0] trial;
  logic [8:0] q_next;
  logic loc_wr;
  logic [7:0] loc_val;

  // Operands for the phase about to be loaded
  always_comb begin
    ld_ph = (cstate == CS_IDLE) ? 2'd0 : cph + 2'd1;
    // Widen first; the square of a 16-bit value needs 32 bits
    ld_num = 41'(norm[ld_ph]) * 41'(norm[ld_ph]) * 41'd100;
    ld_den = vavg[ld_ph] * vavg[ld_ph];
    // Compare in percent; a dead phase counts as too low
    ld_bad = (vavg[ld_ph] == 16'h0000)
           || (24'(vavg[ld_ph]) * 24'd100 < 24'(norm[ld_ph]) * 24'(FAULT_LO_PCT))
           || (24'(vavg[ld_ph]) * 24'd100 > 24'(norm[ld_ph]) * 24'(FAULT_HI_PCT));
    trial = 41'(den) << cbit;
    q_next = quot;
    q_next[cbit] = (rem >= trial);
    loc_val = bad ? CORR_UNITY : ((q_next > 9'd255) ? 8'hFF : q_next[7:0]);
    loc_wr = (cstate == CS_DIV) && (cbit == 4'd0);
  end

  // Restoring divider, one quotient bit per clock, phases in turn
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cstate <= CS_IDLE;
      cph <= 2'd0;
      cbit <= 4'd0;
      rem <= '0;
      den <= 32'h0000_0000;
      quot <= 9'h000;
      bad <= 1'b0;
    end else begin
      case (cstate)
        CS_IDLE: begin
          if (integ_done) begin
            cstate <= CS_DIV;
            cph <= 2'd0;
            cbit <= 4'd8;
            rem <= ld_num;
            den <= ld_den;
            quot <= 9'h000;
            bad <= ld_bad;
          end
        end
        CS_DIV: begin
          quot <= q_next;
          if (rem >= trial) rem <= rem - trial;
          if (cbit == 4'd0) cstate <= CS_NEXT;
          else cbit <= cbit - 4'd1;
        end
        CS_NEXT: begin
          if (cph == 2'd2) begin
            cstate <= CS_IDLE;
          end else begin
            cstate <= CS_DIV;
            cph <= ld_ph;
            cbit <= 4'd8;
            rem <= ld_num;
            den <= ld_den;
            quot <= 9'h000;
            bad <= ld_bad;
          end
        end
        default: cstate <= CS_IDLE;
      endcase
    end
  end

  // Normalizing values and corrections; master writes corrections only when not local
  logic [2:0] corr_chg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < 3; p++) begin
        norm[p] <= NORM_RST;
        corr[p] <= CORR_UNITY;
      end
      corr_chg <= 3'b000;
    end else begin
      corr_chg <= 3'b000;
      if (wr_fire && w_norm) norm[a_ph] <= pwdata[15:0];
      if (loc_wr && local_corr) begin
        corr[cph] <= loc_val;
        corr_chg[cph] <= (loc_val != corr[cph]);
      end else if (wr_fire && w_corr && !local_corr) begin
        corr[a_ph] <= pwdata[7:0];
        corr_chg[a_ph] <= (pwdata[7:0] != corr[a_ph]);
      end
    end
  end

  // Sticky faults; a new fault wins over a write-one clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault <= 3'b000;
      sense_fault <= 1'b0;
    end else begin
      for (int p = 0; p < 3; p++) begin
        if (loc_wr && local_corr && bad && cph == 2'(p)) fault[p] <= 1'b1;
        else if (wr_fire && w_stat && pwdata[p]) fault[p] <= 1'b0;
      end
      sense_fault <= |fault;
    end
  end

  // ****************************************
  // Level calculation
  // ****************************************
  logic [NUM_CH-1:0] set_dirty;
  logic [IDX_W-1:0] eng_idx;
  logic [7:0] calc;
  logic [6:0] e_sp;
  logic [7:0] e_fac;
  logic [7:0] e_corr;
  logic [23:0] prod;
  logic [23:0] steps;

  function automatic logic [1:0] ph_of(input int unsigned ch);
    ph_of = 2'((ch % (3 * CH_PER_PHASE)) / CH_PER_PHASE);
  endfunction

  // Channels touched by this cycle's change
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      set_dirty[i] = (wr_fire && w_chan && a_ch == IDX_W'(i))
                   || (wr_fire && w_fld && ch_fld[i] == a_fld)
                   || corr_chg[ph_of(i)]
                   || (wr_fire && w_ctrl);
    end
  end

  // Output of the channel under the engine
  always_comb begin
    e_corr = comp_en ? corr[ph_of(32'(eng_idx))] : CORR_UNITY;
    e_sp = sp_p1[eng_idx];
    e_fac = fac_stby[ch_fld[eng_idx]];
    if (mode == MODE_PROD1) begin
      e_fac = fac_prod[ch_fld[eng_idx]];
    end else if (mode == MODE_PROD2) begin
      e_sp = sp_p2[eng_idx];
      e_fac = fac_prod[ch_fld[eng_idx]];
    end
    prod = 24'(e_sp) * 24'(e_fac) * 24'(e_corr);
    if (superimp) steps = (prod + HALF_DIV - 24'd1) / HALF_DIV;
    else steps = ((prod + PCT_DIV - 24'd1) / PCT_DIV) << 1;
    calc = (steps > 24'(LVL_MAX)) ? LVL_MAX : steps[7:0];
    if (mode == MODE_STARTUP) calc = {sp_su[eng_idx], 1'b0};
    else if (mode == MODE_OFF) calc = 8'h00;
  end

  // One channel per clock; the rest keep their old level meanwhile
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eng_idx <= '0;
      dirty <= '1;
      for (int i = 0; i < NUM_CH; i++) lvl[i] <= 8'h00;
    end else begin
      eng_idx <= (eng_idx == IDX_W'(NUM_CH - 1)) ? '0 : eng_idx + IDX_W'(1);
      if (dirty[eng_idx]) lvl[eng_idx] <= calc;
      for (int i = 0; i < NUM_CH; i++) begin
        dirty[i] <= set_dirty[i] | (dirty[i] & (eng_idx != IDX_W'(i)));
      end
    end
  end

  // ****************************************
  // Zero crossing timing
  // ****************************************
  logic s1, s2, s3;
  logic zc_lvl;
  logic a_evt;
  logic [HCNT_W-1:0] hcnt;
  logic [HCNT_W-1:0] half;
  logic [HCNT_W-1:0] third;
  logic [HCNT_W+16:0] third_prod; // Full product, no overflow
  logic [2:0] evt_q;     // Crossing pulses, phases a..c
  logic [2:0] pol_q;     // 1 = positive half wave follows

  assign a_evt = (s2 == s3) && (s2 != zc_lvl);
  assign third_prod = {17'h0_0000, half} * {{HCNT_W{1'b0}}, THIRD_MUL};
  assign third = third_prod[16 +: HCNT_W];

  // Three-stage pin synchronizer; only stages two and three are compared
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      zc_lvl <= 1'b0;
    end else begin
      s1 <= zc_phase_a;
      s2 <= s1;
      s3 <= s2;
      if (a_evt) zc_lvl <= s2;
    end
  end

  // Phase c lags a by a third of a half period, b by two thirds
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hcnt <= '0;
      half <= '0;
      locked <= 1'b0;
      evt_q <= 3'b000;
      pol_q <= 3'b000;
    end else begin
      evt_q <= 3'b000;
      if (a_evt) begin
        hcnt <= '0;
        half <= hcnt;
        locked <= (hcnt != '0) && (half != '0);
        evt_q[0] <= 1'b1;
        pol_q[0] <= s2;
      end else begin
        if (hcnt != '1) hcnt <= hcnt + HCNT_W'(1);
        if (locked && hcnt == third) begin
          evt_q[2] <= 1'b1;
          pol_q[2] <= ~pol_q[2];
        end
        if (locked && hcnt == (third << 1)) begin
          evt_q[1] <= 1'b1;
          pol_q[1] <= ~pol_q[1];
        end
      end
    end
  end

  // ****************************************
  // Burst switching per channel
  // ****************************************
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [1:0] PH = ph_of(i);
    localparam logic [8:0] ACC_RST = 9'((i % CH_PER_PHASE) * 100 / CH_PER_PHASE);
    logic [8:0] acc;
    logic [6:0] dcnt;
    logic cyc;
    bal_t bal;
    logic decide;
    logic [8:0] pct;
    logic [8:0] sum;
    logic allowed;

    always_comb begin
      decide = evt_q[PH] & (~full_mode[i] | pol_q[PH]);
      pct = 9'(lvl[i][7:1]) + 9'(lvl[i][0] & cyc);
      sum = acc + pct;
      allowed = full_mode[i] || !((bal == BAL_POS && pol_q[PH]) || (bal == BAL_NEG && !pol_q[PH]));
    end

    // Credit accumulator; a deferred wave keeps its credit
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        acc <= ACC_RST;
        dcnt <= 7'h00;
        cyc <= 1'b0;
        bal <= BAL_EVEN;
        ch_on[i] <= 1'b0;
      end else if (!locked || mode == MODE_OFF) begin
        ch_on[i] <= 1'b0;
        bal <= BAL_EVEN;
      end else if (decide) begin
        dcnt <= (dcnt == WIN_LAST) ? 7'h00 : dcnt + 7'h01;
        if (dcnt == WIN_LAST) cyc <= ~cyc;
        if (sum >= ACC_FULL && allowed) begin
          ch_on[i] <= 1'b1;
          acc <= sum - ACC_FULL;
          if (!full_mode[i]) bal <= (bal != BAL_EVEN) ? BAL_EVEN : (pol_q[PH] ? BAL_POS : BAL_NEG);
        end else begin
          ch_on[i] <= 1'b0;
          acc <= sum;
        end
      end
    end
  end

endmodule

//--- shared/heater_pkg.sv
package heater_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned NUM_CH_DEF = 24;    // Channels of one output module
  localparam int unsigned NUM_FLD_DEF = 4;    // Fields held in the field table
  localparam int unsigned CH_PER_PHASE = 8;   // Channels fed by one phase
  localparam int unsigned HCNT_W_DEF = 24;    // Half-period timer width

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] CTRL_OFS = 12'h0000;
  localparam logic [11:0] STAT_OFS = 12'h0004;
  localparam logic [11:0] INTEG_OFS = 12'h0008;
  localparam logic [11:0] NORM_OFS = 12'h0010;   // Three words, phase a..c
  localparam logic [11:0] CORR_OFS = 12'h0020;   // Three words, phase a..c
  localparam logic [11:0] FIELD_OFS = 12'h0040;  // One word per field
  localparam logic [11:0] CHAN_OFS = 12'h0100;   // One word per channel

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_COMP_BIT = 3;
  localparam int unsigned CTRL_SENSE_BIT = 4;
  localparam int unsigned CTRL_SUPER_BIT = 5;
  localparam int unsigned STAT_LOCK_BIT = 3;
  localparam int unsigned STAT_BUSY_BIT = 4;
  localparam int unsigned FLD_PROD_LSB = 0;
  localparam int unsigned FLD_STBY_LSB = 8;
  localparam int unsigned CH_SU_LSB = 0;
  localparam int unsigned CH_P1_LSB = 8;
  localparam int unsigned CH_P2_LSB = 16;
  localparam int unsigned CH_FLD_LSB = 24;
  localparam int unsigned CH_FULL_BIT = 28;

  // ****************************************
  // Values and reset values
  // ****************************************
  localparam logic [6:0] SP_MAX = 7'h64;           // 100 percent
  localparam logic [7:0] CORR_UNITY = 8'h64;       // 100 percent, factor one
  localparam logic [7:0] LVL_MAX = 8'h00C8;        // 200 half-percent steps
  localparam logic [23:0] PCT_DIV = 24'h00_2710;   // 10000: percent scale
  localparam logic [23:0] HALF_DIV = 24'h00_1388;  // 5000: half-percent scale
  localparam logic [8:0] ACC_FULL = 9'h064;        // Accumulator wrap at 100
  localparam logic [6:0] WIN_LAST = 7'h63;         // 100 decisions per window
  localparam logic [7:0] FAULT_LO_PCT = 8'h50;     // 80 percent
  localparam logic [7:0] FAULT_HI_PCT = 8'h78;     // 120 percent
  localparam logic [16:0] THIRD_MUL = 17'h0_5556;  // One third in 16-bit fraction
  localparam logic [4:0] INTEG_RST = 5'h04;        // 16 samples per integration
  localparam logic [15:0] NORM_RST = 16'h0000;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_STARTUP = 3'b001,
    MODE_STANDBY = 3'b011,
    MODE_PROD1 = 3'b010,
    MODE_PROD2 = 3'b110
  } mode_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_DIV = 2'b01,
    CS_NEXT = 2'b11
  } corr_state_t;

  typedef enum logic [1:0] {
    BAL_EVEN = 2'b00,
    BAL_POS = 2'b01,
    BAL_NEG = 2'b10
  } bal_t;

endpackage

//--- verification/heater_checker.sv
`timescale 1ns/1ps
module heater_checker #(
  parameter int unsigned NUM_CH = 24
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic zc_phase_a,
  input wire logic [NUM_CH-1:0] ch_on,
  input wire logic sense_fault
);
  // ****
  // Port rules
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_one_wait: assert property (psel && !penable ##1 psel && penable |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_cause: assert property (pready |-> psel && penable && $past(penable)) else $error("stray ready");
  a_read_quiet: assert property (!pready |-> prdata == 0) else $error("data outside ready");
  a_err_qual: assert property (pslverr |-> pready) else $error("error without ready");
  // Phase a channels move only just after a pin edge
  a_zc_sync: assert property ($changed(ch_on[7:0]) |-> $past(zc_phase_a, 3) != $past(zc_phase_a, 7))
    else $error("switch off crossing");
  a_fault_sticky: assert property ($fell(sense_fault) |-> $past(pwrite && pready, 2))
    else $error("fault dropped");
  a_reset_quiet: assert property ($rose(rst_b) |-> ch_on == 0 && !sense_fault) else $error("busy reset");
endmodule
bind heater_level_burst heater_checker #(.NUM_CH(NUM_CH)) i_chk (.clk, .rst_b, .psel, .penable, .pwrite,
  .pready, .prdata, .pslverr, .zc_phase_a, .ch_on, .sense_fault);

//--- verification/mains_model.sv
`timescale 1ns/1ps
module mains_model #(
  parameter int HALF = 100
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] volt_a,
  input wire logic [15:0] volt_b,
  input wire logic [15:0] volt_c,
  output logic zc_phase_a,
  output logic vsample_valid,
  output logic [15:0] vsample_a,
  output logic [15:0] vsample_b,
  output logic [15:0] vsample_c
);
  // ****
  // Mains and sensing
  // ****
  int cnt;
  // Phase a polarity and a rare sample strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      zc_phase_a <= 1'b0;
      vsample_valid <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      if (cnt % HALF == HALF - 1) zc_phase_a <= ~zc_phase_a;
      vsample_valid <= (cnt % 64 == 0);
    end
  end
  // Junk between strobes so stale data cannot pass
  assign vsample_a = vsample_valid ? volt_a : ~volt_a;
  assign vsample_b = vsample_valid ? volt_b : ~volt_b;
  assign vsample_c = vsample_valid ? volt_c : ~volt_c;
endmodule

//--- verification/heater_level_burst_bench.sv
`timescale 1ns/1ps
module heater_level_burst_bench;
  import heater_pkg::*;
  // ****
  // Bench
  // ****
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, zc_phase_a, vsample_valid, sense_fault;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] vsample_a, vsample_b, vsample_c, volt_a, volt_b, volt_c;
  logic [23:0] ch_on;
  note_t q[$];
  note_t n;
  int fails = 0, cmp_count = 0, cycles = 0, seed;
  heater_level_burst #(.HCNT_W(12)) i_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .zc_phase_a, .vsample_valid, .vsample_a, .vsample_b, .vsample_c, .ch_on, .sense_fault);
  mains_model #(.HALF(100)) i_mains (.clk, .rst_b, .volt_a, .volt_b, .volt_c, .zc_phase_a, .vsample_valid,
    .vsample_a, .vsample_b, .vsample_c);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (e !== s) begin
      fails++;
      $display("MISMATCH %s exp=%h seen=%h", nm, e, s);
    end
  endtask
  // One bus word; the note is queued for the monitor
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e = 0, input logic [31:0] m = 0, input logic er = 0);
    q.push_back('{e, m, er});
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  // Expected whole percent: rounded up, capped
  function automatic int pct(input int sp, input int f, input int c);
    return (sp * f * c >= 1000000) ? 100 : (sp * f * c + 9999) / 10000;
  endfunction
  // Count on half waves of channel 0 over 100 half waves
  task automatic level(input logic [31:0] ctrl, input int e);
    int k = 0;
    apb(1, CTRL_OFS, ctrl);
    repeat (8) @(zc_phase_a);
    repeat (100) begin
      @(zc_phase_a);
      repeat (50) @(posedge clk);
      if (ch_on[0] === 1'b1) k++;
    end
    cmp_count++;
    if (k < e - 1 || k > e + 1) begin
      fails++;
      $display("MISMATCH level exp=%0d seen=%0d", e, k);
    end
  endtask
  // Monitor and watchdog
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 90000) begin
      fails++;
      finish_test();
    end
    if (pready === 1'b1) begin
      n = q.pop_front();
      check("prdata", n.d & n.m, prdata & n.m);
      check("pslverr", {31'h0, n.e}, {31'h0, pslverr});
    end
  end
  initial begin
    seed = 32'hb3bf;
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {volt_a, volt_b, volt_c} = {16'h0384, 16'h02BC, 16'h03E8};
    repeat (10) @(posedge clk);
    rst_b <= 1;
    apb(0, CORR_OFS, 0, 32'h0000_0064, 32'hFFFF_FFFF);
    apb(1, INTEG_OFS, 32'h0000_0001);
    for (int p = 0; p < 3; p++) apb(1, NORM_OFS + 12'(4 * p), 32'h0000_03E8);
    apb(1, CHAN_OFS, 32'h001E_2825);
    apb(1, FIELD_OFS, 32'h0000_3296);
    apb(1, CTRL_OFS, 32'h0000_0018);
    repeat (2000) @(posedge clk);
    apb(1, CORR_OFS + 12'h008, 32'h0000_0055);
    apb(0, CORR_OFS, 0, 32'h0000_007B, 32'h0000_00FF);
    apb(0, CORR_OFS + 12'h004, 0, 32'h0000_0064, 32'h0000_00FF);
    apb(0, CORR_OFS + 12'h008, 0, 32'h0000_0064, 32'h0000_00FF);
    apb(0, STAT_OFS, 0, 32'h0000_000A, 32'h0000_000F);
    check("sense_fault", 1, {31'h0, sense_fault});
    volt_b <= 16'h03E8;
    repeat (500) @(posedge clk);
    apb(1, STAT_OFS, 32'h0000_0007);
    apb(0, STAT_OFS, 0, 32'h0000_0008, 32'h0000_000F);
    apb(1, 12'hFFC, $random(seed), 0, 0, 1);
    apb(0, 12'h002, 0, 0, 32'hFFFF_FFFF, 1);
    check("sense_fault", 0, {31'h0, sense_fault});
    apb(1, CTRL_OFS, 32'h0000_0008);
    apb(1, CORR_OFS, 32'h0000_006E);
    level(32'(MODE_STARTUP) | 32'h0000_0008, 37);
    level(32'(MODE_STANDBY) | 32'h0000_0008, pct(40, 50, 110));
    level(32'(MODE_PROD1) | 32'h0000_0008, pct(40, 150, 110));
    level(32'(MODE_PROD2) | 32'h0000_0008, pct(30, 150, 110));
    apb(1, CHAN_OFS, 32'h101E_2825);
    level(32'(MODE_PROD2) | 32'h0000_0008, pct(30, 150, 110));
    apb(1, FIELD_OFS, 32'h0000_32FF);
    level(32'(MODE_PROD1) | 32'h0000_0028, pct(40, 255, 110));
    finish_test();
  end
endmodule
